// ---- rtl/cam_measure_ctrl.sv ----
// acquisition sequencer, result packing and register file for the
// cell, module-voltage and auxiliary measurement channels
// assumes an external converter with a start pulse and a done strobe
//
// How it works
// - only cells whose mask bit is set are converted; cell n is input n minus n-1
// - first 12-bit conversion of each cell and the module is held in an accumulator for averaging
// - averaged result is the 13-bit pair sum in bits 15:3, low three bits zero
// - disabled channels read all zero after an acquisition
// - one 14-bit step is 5V divided by 16384
// - bipolar select shifts cell coding to -2.5V..2.5V, mid-scale 2000h
// - diagnostic force input overrides the bipolar select bit
// - module voltage converted when enabled, stored in its result register
// - divider stays off after reset; on only while top enable bit set
// - each auxiliary input converted only when its enable bit is set
// - auxiliary inputs converted once, stored unaveraged as 12 bits
// - auxiliary conversions use the thermistor-bias supply as reference
// - bias mode 00/01 follow acquisition, 10 holds on, 11 holds off
// - extra settling per auxiliary is 6us plus count times 6us
// - auxiliary inputs are converted last in the acquisition
// - settling runs right before each enabled auxiliary conversion
// - start strobe reads zero; completion flag set when acquisition ends
`timescale 1ns/1ns
module cam_measure_ctrl
  import cam_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [cam_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cam_pkg::DATA_W-1:0] reg_wdata,
  output logic [cam_pkg::DATA_W-1:0] reg_rdata,
  input wire logic diag_force_en,
  input wire logic diag_force_bipolar,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output logic adc_start,
  output logic [3:0] adc_chan,
  output logic adc_bipolar,
  output logic adc_ref_thermistor,
  output logic thermistor_bias_out,
  output logic divider_connect,
  output logic acq_busy
);
  import cam_pkg::*;

  function automatic logic chan_enabled(input logic [3:0] ch,
                                        input logic [15:0] en);
    if (ch <= LAST_CELL)
      return en[ch];
    else if (ch == CH_MODULE)
      return en[MEN_MODULE_BIT];
    else if (ch == CH_AUX1)
      return en[MEN_AUX1_BIT];
    else
      return en[MEN_AUX2_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] meas_en_q;
  logic [15:0] acq_cfg_q;
  logic polarity_q;
  logic done_q;
  logic [15:0] en_snap_q;
  logic pol_snap_q;
  logic [5:0] settle_snap_q;
  logic [15:0] result_q [NUM_RESULTS];
  logic [11:0] acc_q [13];
  cam_state_t st_q;
  cam_phase_t ph_q;
  cam_phase_t ph_d;
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic last_d;
  logic [3:0] chan_d;
  logic [11:0] settle_cnt_q;
  logic adc_start_q;
  logic [3:0] adc_chan_q;
  logic adc_bipolar_q;
  logic adc_ref_q;
  logic bias_q;
  logic divider_q;
  logic [15:0] rdata_q;
  logic busy_q;
  logic start_req;
  logic [12:0] pair_sum;
  logic [11:0] settle_load;

  assign start_req = reg_wr && reg_addr == ADDR_SCAN_CTRL &&
                     reg_wdata[SC_START_BIT] && st_q == ST_IDLE;
  assign pair_sum = {1'b0, acc_q[adc_chan_q]} + {1'b0, adc_data};
  assign settle_load = 12'((settle_snap_q + 7'd1) * SETTLE_STEP_CYC) -
                       12'd1;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock) begin
    if (srst) begin
      meas_en_q <= MEAS_EN_RST;
      acq_cfg_q <= ACQ_CFG_RST;
      polarity_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MEAS_EN)
        meas_en_q <= reg_wdata;
      if (reg_addr == ADDR_ACQ_CFG)
        acq_cfg_q <= reg_wdata;
      if (reg_addr == ADDR_SCAN_CTRL)
        polarity_q <= reg_wdata[SC_POLARITY_BIT];
    end
  end

  // snapshot so a rewrite mid-acquisition cannot mix two setups
  always_ff @(posedge clock) begin
    if (srst) begin
      en_snap_q <= 16'h0000;
      pol_snap_q <= 1'b0;
      settle_snap_q <= 6'h00;
    end else if (start_req) begin
      en_snap_q <= meas_en_q;
      pol_snap_q <= polarity_q;
      settle_snap_q <= acq_cfg_q[ACQ_SETTLE_LSB +: 6];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next scan position; cells go up then down, auxiliaries come last
  always_comb begin
    ph_d = ph_q;
    idx_d = idx_q;
    last_d = 1'b0;
    chan_d = idx_q;
    unique case (ph_q)
      PH_MOD1: begin
        chan_d = CH_MODULE;
        ph_d = PH_UP;
        idx_d = 4'h0;
      end
      PH_UP: begin
        if (idx_q == LAST_CELL)
          ph_d = PH_DN;
        else
          idx_d = idx_q + 4'h1;
      end
      PH_DN: begin
        if (idx_q == 4'h0)
          ph_d = PH_MOD2;
        else
          idx_d = idx_q - 4'h1;
      end
      PH_MOD2: begin
        chan_d = CH_MODULE;
        ph_d = PH_AUX;
        idx_d = 4'h0;
      end
      PH_AUX: begin
        chan_d = (idx_q == 4'h0) ? CH_AUX1 : CH_AUX2;
        idx_d = 4'h1;
        last_d = idx_q != 4'h0;
      end
      default: begin
        ph_d = PH_MOD1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= ST_IDLE;
      ph_q <= PH_MOD1;
      idx_q <= 4'h0;
      settle_cnt_q <= 12'h000;
      adc_start_q <= 1'b0;
      adc_chan_q <= 4'h0;
      adc_bipolar_q <= 1'b0;
      adc_ref_q <= 1'b0;
    end else begin
      adc_start_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (start_req) begin
            st_q <= ST_SELECT;
            ph_q <= PH_MOD1;
            idx_q <= 4'h0;
          end
        end
        ST_SELECT: begin
          adc_chan_q <= chan_d;
          if (chan_enabled(chan_d, en_snap_q)) begin
            settle_cnt_q <= settle_load;
            st_q <= (ph_q == PH_AUX) ? ST_SETTLE : ST_START;
          end else if (last_d) begin
            st_q <= ST_FINISH;
          end else begin
            ph_q <= ph_d;
            idx_q <= idx_d;
          end
        end
        ST_SETTLE: begin
          if (settle_cnt_q == 12'h000)
            st_q <= ST_START;
          else
            settle_cnt_q <= settle_cnt_q - 12'h001;
        end
        ST_START: begin
          adc_start_q <= 1'b1;
          adc_ref_q <= adc_chan_q >= CH_AUX1;
          if (adc_chan_q <= LAST_CELL)
            adc_bipolar_q <= diag_force_en ? diag_force_bipolar
                                           : pol_snap_q;
          else
            adc_bipolar_q <= 1'b0;
          st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (adc_done) begin
            if (last_d) begin
              st_q <= ST_FINISH;
            end else begin
              st_q <= ST_SELECT;
              ph_q <= ph_d;
              idx_q <= idx_d;
            end
          end
        end
        ST_FINISH: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulators and result packing
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < 13; i++)
        acc_q[i] <= 12'h000;
    end else if (st_q == ST_WAIT && adc_done && adc_chan_q <= CH_MODULE &&
                 (ph_q == PH_MOD1 || ph_q == PH_UP)) begin
      acc_q[adc_chan_q] <= adc_data;
    end
  end

  // two conversions summed give the 12-bit mean times two, so the
  // 13-bit sum lands in bits 15:3 and bit 2 is always zero
  always_ff @(posedge clock) begin
    if (srst || start_req) begin
      for (int i = 0; i < NUM_RESULTS; i++)
        result_q[i] <= RESULT_RST;
    end else if (st_q == ST_WAIT && adc_done) begin
      if (adc_chan_q >= CH_AUX1)
        result_q[adc_chan_q] <= {4'h0, adc_data};
      else if (ph_q == PH_DN || ph_q == PH_MOD2)
        result_q[adc_chan_q] <= {pair_sum, 3'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // completion flag: a finishing acquisition beats a clearing write
  always_ff @(posedge clock) begin
    if (srst)
      done_q <= 1'b0;
    else if (st_q == ST_FINISH)
      done_q <= 1'b1;
    else if (start_req || (reg_wr && reg_addr == ADDR_SCAN_CTRL &&
                           reg_wdata[SC_DONE_BIT]))
      done_q <= 1'b0;
  end

  // busy as a flop of its own so the pin never glitches on state decode
  always_ff @(posedge clock) begin
    if (srst)
      busy_q <= 1'b0;
    else if (start_req)
      busy_q <= 1'b1;
    else if (st_q == ST_FINISH)
      busy_q <= 1'b0;
  end

  // analog-side controls
  always_ff @(posedge clock) begin
    if (srst) begin
      bias_q <= 1'b0;
      divider_q <= 1'b0;
    end else begin
      divider_q <= meas_en_q[MEN_DIVIDER_BIT];
      unique case (acq_cfg_q[ACQ_BIAS_LSB +: 2])
        BIAS_HOLD_ON: bias_q <= 1'b1;
        BIAS_HOLD_OFF: bias_q <= 1'b0;
        default: bias_q <= start_req ||
                           (st_q != ST_IDLE && st_q != ST_FINISH);
      endcase
    end
  end

  // register read port, one cycle of latency
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_MEAS_EN)
        rdata_q <= meas_en_q;
      else if (reg_addr == ADDR_ACQ_CFG)
        rdata_q <= acq_cfg_q;
      else if (reg_addr == ADDR_SCAN_CTRL)
        rdata_q <= 16'({st_q != ST_IDLE, polarity_q, done_q, 1'b0});
      else if (reg_addr >= ADDR_RESULT_BASE &&
               reg_addr < ADDR_RESULT_BASE + 8'(NUM_RESULTS))
        rdata_q <= result_q[4'(reg_addr - ADDR_RESULT_BASE)];
      else
        rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign adc_start = adc_start_q;
  assign adc_chan = adc_chan_q;
  assign adc_bipolar = adc_bipolar_q;
  assign adc_ref_thermistor = adc_ref_q;
  assign thermistor_bias_out = bias_q;
  assign divider_connect = divider_q;
  assign acq_busy = busy_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic aux_seen_q;
  always_ff @(posedge clock) begin
    if (srst || start_req)
      aux_seen_q <= 1'b0;
    else if (adc_start_q && adc_chan_q >= CH_AUX1)
      aux_seen_q <= 1'b1;
  end

  property p_cell_enabled;
    @(posedge clock) disable iff (srst)
      adc_start_q && adc_chan_q <= LAST_CELL |-> en_snap_q[adc_chan_q];
  endproperty
  a_cell_enabled: assert property (p_cell_enabled)
    else $error("disabled cell converted");

  property p_low_bits;
    @(posedge clock) disable iff (srst)
      st_q == ST_FINISH |=> result_q[0][1:0] == 2'h0;
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("cell result low bits not zero");

  property p_disabled_zero;
    @(posedge clock) disable iff (srst)
      st_q == ST_FINISH && !en_snap_q[0] |=> result_q[0] == 16'h0000;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero)
    else $error("disabled channel result not zero");

  property p_polarity;
    @(posedge clock) disable iff (srst)
      adc_start_q && adc_chan_q <= LAST_CELL && !$past(diag_force_en)
      |-> adc_bipolar_q == pol_snap_q;
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("cell polarity differs from setting");

  property p_divider;
    @(posedge clock) disable iff (srst)
      ##1 divider_q == $past(meas_en_q[MEN_DIVIDER_BIT]);
  endproperty
  a_divider: assert property (p_divider)
    else $error("divider connect does not follow its bit");

  property p_aux_enabled;
    @(posedge clock) disable iff (srst)
      adc_start_q && adc_chan_q == CH_AUX2 |-> en_snap_q[MEN_AUX2_BIT];
  endproperty
  a_aux_enabled: assert property (p_aux_enabled)
    else $error("disabled auxiliary converted");

  property p_aux_ref;
    @(posedge clock) disable iff (srst)
      adc_start_q |-> adc_ref_q == (adc_chan_q >= CH_AUX1);
  endproperty
  a_aux_ref: assert property (p_aux_ref)
    else $error("wrong converter reference");

  property p_bias_manual;
    @(posedge clock) disable iff (srst)
      (acq_cfg_q[ACQ_BIAS_LSB +: 2] == BIAS_HOLD_OFF) [*2] |-> !bias_q;
  endproperty
  a_bias_manual: assert property (p_bias_manual)
    else $error("bias on while held off");

  property p_settle;
    @(posedge clock) disable iff (srst)
      st_q == ST_SELECT ##1 st_q == ST_SETTLE && settle_snap_q == 6'h00
      |-> ##60 st_q == ST_START;
  endproperty
  a_settle: assert property (p_settle)
    else $error("auxiliary settling length wrong");

  property p_aux_last;
    @(posedge clock) disable iff (srst)
      adc_start_q && adc_chan_q <= CH_MODULE |-> !aux_seen_q;
  endproperty
  a_aux_last: assert property (p_aux_last)
    else $error("cell or module converted after auxiliary");

  property p_done;
    @(posedge clock) disable iff (srst)
      st_q == ST_FINISH |=> done_q && !acq_busy;
  endproperty
  a_done: assert property (p_done)
    else $error("completion flag not set");

  property p_aux_align;
    @(posedge clock) disable iff (srst)
      result_q[CH_AUX1][15:12] == 4'h0;
  endproperty
  a_aux_align: assert property (p_aux_align)
    else $error("auxiliary result upper bits set");
endmodule

// ---- rtl/cam_pkg.sv ----
// constants and types for the cell and auxiliary measurement control block
// assumes a 10 MHz core clock and a simple word-wide register port
package cam_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SETTLE_STEP_NS = 6000;
  localparam int unsigned SETTLE_STEP_CYC_RAW =
    (SETTLE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_STEP_CYC =
    (SETTLE_STEP_CYC_RAW < 1) ? 1 : SETTLE_STEP_CYC_RAW;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CELLS = 12;
  localparam int NUM_RESULTS = 15;
  localparam logic [3:0] CH_MODULE = 4'hc;
  localparam logic [3:0] CH_AUX1 = 4'hd;
  localparam logic [3:0] CH_AUX2 = 4'he;
  localparam logic [3:0] LAST_CELL = 4'hb;
  // register indices
  localparam logic [7:0] ADDR_MEAS_EN = 8'h00;
  localparam logic [7:0] ADDR_ACQ_CFG = 8'h01;
  localparam logic [7:0] ADDR_SCAN_CTRL = 8'h02;
  localparam logic [7:0] ADDR_RESULT_BASE = 8'h10;
  // measurement_enable fields
  localparam int MEN_AUX1_BIT = 12;
  localparam int MEN_AUX2_BIT = 13;
  localparam int MEN_MODULE_BIT = 14;
  localparam int MEN_DIVIDER_BIT = 15;
  // acquisition_config fields
  localparam int ACQ_SETTLE_LSB = 0;
  localparam int ACQ_BIAS_LSB = 8;
  localparam logic [1:0] BIAS_HOLD_ON = 2'h2;
  localparam logic [1:0] BIAS_HOLD_OFF = 2'h3;
  // scan control fields
  localparam int SC_START_BIT = 0;
  localparam int SC_DONE_BIT = 1;
  localparam int SC_POLARITY_BIT = 2;
  localparam int SC_BUSY_BIT = 3;
  localparam logic [15:0] MEAS_EN_RST = 16'h0000;
  localparam logic [15:0] ACQ_CFG_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SELECT, ST_SETTLE, ST_START, ST_WAIT, ST_FINISH
  } cam_state_t;
  typedef enum logic [2:0] {
    PH_MOD1, PH_UP, PH_DN, PH_MOD2, PH_AUX
  } cam_phase_t;
endpackage

// ---- tb/cam_conv_model.sv ----
// converter plus measured cell stack and thermistor dividers
// assumes the sequencer pulses adc_start and then waits for adc_done
`timescale 1ns/1ns
module cam_conv_model (
  input wire logic clock,
  input wire logic clr,
  input wire logic adc_start,
  input wire logic [3:0] adc_chan,
  input wire logic adc_bipolar,
  input wire logic adc_ref_thermistor,
  output logic adc_done,
  output logic [11:0] adc_data
);
  logic [12:0] acc [15];
  int cnt [15], gap [15];
  logic bip [15], refth [15];
  int order_bad, wait_n, idle_n;
  logic saw_aux;
  logic [3:0] ch_q;
  logic [3:0] pc;
  logic [11:0] d_v;
  initial begin
    adc_done = 1'b0;
    adc_data = 12'h000;
    wait_n = -1;
    idle_n = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // answers after 0..3 idle cycles; data bus churns when not valid so a
  // stale value can never pass for a fresh result
  always @(posedge clock) begin
    adc_done <= 1'b0;
    adc_data <= 12'($urandom);
    idle_n <= idle_n + 1;
    // settling is counted from the moment the channel is selected
    pc <= adc_chan;
    if (adc_chan != pc) idle_n <= 0;
    if (clr) begin
      for (int i = 0; i < 15; i++) begin
        acc[i] <= '0;
        cnt[i] <= 0;
      end
      order_bad <= 0;
      saw_aux <= 1'b0;
      wait_n <= -1;
    end else if (adc_start) begin
      ch_q <= adc_chan;
      bip[adc_chan] <= adc_bipolar;
      refth[adc_chan] <= adc_ref_thermistor;
      gap[adc_chan] <= idle_n;
      if (adc_chan < 4'hd && saw_aux) order_bad <= order_bad + 1;
      if (adc_chan >= 4'hd) saw_aux <= 1'b1;
      wait_n <= int'($urandom_range(3, 0));
    end else if (wait_n == 0) begin
      d_v = 12'($urandom);
      adc_done <= 1'b1;
      adc_data <= d_v;
      acc[ch_q] <= acc[ch_q] + 13'(d_v);
      cnt[ch_q] <= cnt[ch_q] + 1;
      wait_n <= -1;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
    end
  end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the measurement sequencer and its registers
// assumes the converter model answers every conversion start
`timescale 1ns/1ns
module tb;
  import cam_pkg::*;
  logic clock, srst, reg_wr, reg_rd, clr, df_en, df_bip;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv, m, c;
  logic adc_done, adc_start, adc_bipolar, adc_ref_thermistor;
  logic thermistor_bias_out, divider_connect, acq_busy;
  logic [11:0] adc_data;
  logic [3:0] adc_chan;
  logic [7:0] ra [5] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h1e};
  int fail_count, cmp_count;
  cam_measure_ctrl dut_u (.clock(clock), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .diag_force_en(df_en),
    .diag_force_bipolar(df_bip), .adc_done(adc_done), .adc_data(adc_data),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_bipolar(adc_bipolar),
    .adc_ref_thermistor(adc_ref_thermistor),
    .thermistor_bias_out(thermistor_bias_out),
    .divider_connect(divider_connect), .acq_busy(acq_busy));
  cam_conv_model conv_u (.clock(clock), .clr(clr), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_bipolar(adc_bipolar),
    .adc_ref_thermistor(adc_ref_thermistor), .adc_done(adc_done),
    .adc_data(adc_data));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp, string s);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic chk_n(int got, int exp, string s);
    cmp_count++;
    if (got != exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, s, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // waits one spare edge: read data holds until the next read anyway
  task automatic rd(logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1 d = reg_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic int exp_cnt(logic [15:0] mm, int ch);
    if (ch < 12) return mm[ch] ? 2 : 0;
    if (ch == 12) return mm[14] ? 2 : 0;
    return mm[ch - 1] ? 1 : 0;
  endfunction
  function automatic logic [15:0] exp_res(int ch);
    if (conv_u.cnt[ch] == 0) return 16'h0000;
    if (ch >= 13) return {4'h0, conv_u.acc[ch][11:0]};
    return {conv_u.acc[ch], 3'b000};
  endfunction
  task automatic acq(logic [15:0] mm, logic [15:0] cc, logic p);
    int n, lo;
    @(posedge clock);
    clr <= 1'b1;
    df_en <= 1'($urandom);
    df_bip <= 1'($urandom);
    @(posedge clock);
    clr <= 1'b0;
    wr(ADDR_MEAS_EN, mm);
    repeat (2) @(posedge clock);
    chk(16'(divider_connect), 16'(mm[15]), "divider");
    wr(ADDR_ACQ_CFG, cc);
    wr(ADDR_SCAN_CTRL, 16'(p) << SC_POLARITY_BIT);
    wr(ADDR_SCAN_CTRL, (16'(p) << SC_POLARITY_BIT) | 16'h0001);
    repeat (2) @(posedge clock);
    chk(16'(acq_busy), 16'h0001, "busy");
    chk(16'(thermistor_bias_out), 16'(cc[9:8] != BIAS_HOLD_OFF), "bias");
    // rewritten mid-run: conversion counts must still follow mm
    wr(ADDR_MEAS_EN, ~mm);
    n = 0;
    while (acq_busy !== 1'b0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    #1 chk(16'(thermistor_bias_out), 16'(cc[9:8] == BIAS_HOLD_ON), "bias");
    rd(ADDR_SCAN_CTRL, rv);
    chk(rv & 16'h000b, 16'h0002, "scan status");
    lo = (int'(cc[5:0]) + 1) * SETTLE_STEP_CYC;
    for (int ch = 0; ch < 15; ch++) begin
      rd(ADDR_RESULT_BASE + 8'(ch), rv);
      chk(rv, exp_res(ch), "result");
      chk_n(conv_u.cnt[ch], exp_cnt(mm, ch), "conversions");
      if (conv_u.cnt[ch] > 0) begin
        chk(16'(conv_u.refth[ch]), 16'(ch >= 13), "reference");
        chk(16'(conv_u.bip[ch]), 16'(ch < 12 && (df_en ? df_bip : p)),
          "coding");
      end
      if (ch >= 13 && conv_u.cnt[ch] > 0)
        chk_n(int'(conv_u.gap[ch] >= lo && conv_u.gap[ch] <= lo + 8), 1,
          "settle");
    end
    chk_n(conv_u.order_bad, 0, "aux order");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    df_en = 1'b0;
    df_bip = 1'b0;
    clr = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(22));
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    #1 chk(16'(divider_connect), 16'h0000, "divider reset");
    foreach (ra[i]) begin
      rd(ra[i], rv);
      chk(rv, 16'h0000, "reset value");
    end
    wr(8'h55, 16'hffff);
    rd(8'h55, rv);
    chk(rv, 16'h0000, "unmapped");
    acq(16'h7fff, 16'h0200, 1'b1);
    acq(16'h7fff, 16'h0300, 1'b0);
    acq(16'h9000, 16'h033f, 1'b0);
    acq(16'ha001, 16'h0105, 1'b1);
    for (int i = 0; i < 8; i++) begin
      m = 16'($urandom);
      m[12] = m[12] | ~m[13];
      c = {6'h00, 2'($urandom), 2'h0, 6'($urandom_range(3, 0))};
      acq(m, c, 1'($urandom));
    end
    close_out();
  end
  initial begin
    #(50000 * 100);
    fail_count++;
    close_out();
  end
endmodule
